// [logic/scc_pkg.sv]
// Package of constants and types for the conversion controller
package scc_pkg;
    localparam int RES_BITS = 16;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_FULL = 16'hffff;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam int CLK_HZ = 20000000;
    localparam int MAX_RATE_SPS = 600000;
    localparam int CYCLES_PER_SAMPLE = CLK_HZ / MAX_RATE_SPS;
    localparam int SWITCH_SETTLE_CYC = 1;
    localparam int BIT_CYC = 1;

    typedef enum logic [2:0] {
        SCC_ACQ = 3'b000,
        SCC_OPEN_GND = 3'b001,
        SCC_HOLD = 3'b011,
        SCC_BITS = 3'b010,
        SCC_DONE = 3'b110
    } scc_state_type;
endpackage : scc_pkg

// [logic/scc_trigger_sync.sv]
// Synchroniser and rising edge detector for the conversion trigger
`timescale 1ns/1ps
module scc_trigger_sync (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic conversion_trigger,
    output logic trigger_rise
);
    logic meta;
    logic sync;
    logic sync_d;
    logic next_meta;
    logic next_sync;
    logic next_sync_d;
    logic next_rise;

    always_comb begin
        next_meta = conversion_trigger;
        next_sync = meta;
        next_sync_d = sync;
        next_rise = sync & ~sync_d;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
            trigger_rise <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            sync_d <= next_sync_d;
            trigger_rise <= next_rise;
        end
    end
endmodule : scc_trigger_sync

// [logic/scc_controller.sv]
// Successive approximation conversion controller
`timescale 1ns/1ps
module scc_controller #(
    parameter int BITS = scc_pkg::RES_BITS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic conversion_trigger,
    input wire logic comparator_high,
    output logic positive_ground_switch,
    output logic negative_ground_switch,
    output logic array_to_input,
    output logic [BITS-1:0] dac_positive_ref,
    output logic [BITS-1:0] dac_negative_ref,
    output logic [BITS-1:0] result_code,
    output logic result_valid,
    output logic busy,
    output logic powered_up
);
    // Widths the logic can serve
    if (BITS < 2 || BITS > 32) begin : g_bits_check
        $error("BITS must lie between 2 and 32");
    end

    // One cycle per switch and bit step
    if (scc_pkg::SWITCH_SETTLE_CYC != 1 || scc_pkg::BIT_CYC != 1) begin : g_step_check
        $error("Only one cycle per conversion step is served");
    end

    localparam logic [4:0] LAST_BIT = 5'(BITS - 1);
    localparam logic [BITS-1:0] RESET_CODE = BITS'(scc_pkg::CODE_ZERO);

    logic trigger_rise;
    scc_pkg::scc_state_type state;
    scc_pkg::scc_state_type next_state;
    logic [4:0] bit_idx;
    logic [4:0] next_bit_idx;
    logic [BITS-1:0] sar;
    logic [BITS-1:0] next_sar;
    logic next_pos_gnd;
    logic next_neg_gnd;
    logic next_to_input;
    logic next_in_bits;
    logic [BITS-1:0] next_dac_pos;
    logic [BITS-1:0] next_dac_neg;
    logic [BITS-1:0] next_code;
    logic next_valid;
    logic next_busy;
    logic next_power;

    scc_trigger_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .conversion_trigger(conversion_trigger),
        .trigger_rise(trigger_rise)
    );

    // Sequencer
    always_comb begin
        next_state = state;
        next_bit_idx = bit_idx;
        unique case (state)
            scc_pkg::SCC_ACQ: begin
                if (trigger_rise) begin
                    next_state = scc_pkg::SCC_OPEN_GND;
                end
            end
            scc_pkg::SCC_OPEN_GND: begin
                next_state = scc_pkg::SCC_HOLD;
            end
            scc_pkg::SCC_HOLD: begin
                next_bit_idx = LAST_BIT;
                next_state = scc_pkg::SCC_BITS;
            end
            scc_pkg::SCC_BITS: begin
                if (bit_idx != 5'h00) begin
                    next_bit_idx = bit_idx - 5'h01;
                end else begin
                    next_state = scc_pkg::SCC_DONE;
                end
            end
            scc_pkg::SCC_DONE: begin
                next_state = scc_pkg::SCC_ACQ;
            end
            default: begin
                next_state = scc_pkg::SCC_ACQ;
                next_bit_idx = 5'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= scc_pkg::SCC_ACQ;
            bit_idx <= 5'h00;
        end else begin
            state <= next_state;
            bit_idx <= next_bit_idx;
        end
    end

    // Per element trial, decision and drive
    for (genvar i = 0; i < BITS; i++) begin : g_elem
        localparam logic [4:0] SELF = 5'(i);
        localparam logic [4:0] ABOVE = 5'(i + 1);
        localparam bit TOP = (i == BITS - 1);
        logic trial;
        logic lower;
        assign trial = (state == scc_pkg::SCC_BITS) && (bit_idx == SELF);
        assign lower = !TOP && (state == scc_pkg::SCC_BITS) && (bit_idx == ABOVE);
        assign next_sar[i] = (state == scc_pkg::SCC_HOLD) ? TOP
            : trial ? comparator_high
            : lower ? 1'b1
            : sar[i];
        assign next_dac_pos[i] = next_in_bits & next_sar[i];
        assign next_dac_neg[i] = next_in_bits & ~next_sar[i];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sar <= RESET_CODE;
        end else begin
            sar <= next_sar;
        end
    end

    // Array drive enable
    always_comb begin
        next_in_bits = (next_state == scc_pkg::SCC_BITS);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dac_positive_ref <= '0;
            dac_negative_ref <= '0;
        end else begin
            dac_positive_ref <= next_dac_pos;
            dac_negative_ref <= next_dac_neg;
        end
    end

    // Switches
    always_comb begin
        next_pos_gnd = (next_state == scc_pkg::SCC_ACQ);
        next_neg_gnd = (next_state == scc_pkg::SCC_ACQ);
        next_to_input = (next_state == scc_pkg::SCC_ACQ)
            || (next_state == scc_pkg::SCC_OPEN_GND);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            positive_ground_switch <= 1'b1;
            negative_ground_switch <= 1'b1;
            array_to_input <= 1'b1;
        end else begin
            positive_ground_switch <= next_pos_gnd;
            negative_ground_switch <= next_neg_gnd;
            array_to_input <= next_to_input;
        end
    end

    // Result
    always_comb begin
        next_code = result_code;
        next_valid = 1'b0;
        if (state == scc_pkg::SCC_DONE) begin
            next_code = sar;
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            result_code <= RESET_CODE;
            result_valid <= 1'b0;
        end else begin
            result_code <= next_code;
            result_valid <= next_valid;
        end
    end

    // Status
    always_comb begin
        next_busy = (next_state != scc_pkg::SCC_ACQ);
        next_power = (next_state != scc_pkg::SCC_ACQ);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            powered_up <= 1'b0;
        end else begin
            busy <= next_busy;
            powered_up <= next_power;
        end
    end
endmodule : scc_controller

// [test/scc_controller_props.sv]
// Port assertions for the conversion controller
`timescale 1ns/1ps
module scc_controller_props #(
    parameter int BITS = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic positive_ground_switch,
    input wire logic negative_ground_switch,
    input wire logic array_to_input,
    input wire logic [BITS-1:0] dac_positive_ref,
    input wire logic [BITS-1:0] dac_negative_ref,
    input wire logic [BITS-1:0] result_code,
    input wire logic result_valid,
    input wire logic busy,
    input wire logic powered_up
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    property p_acq;
        !busy |-> positive_ground_switch && negative_ground_switch && array_to_input;
    endproperty
    a_acq: assert property (p_acq) else $error("acq switches");
    property p_gnd;
        $fell(array_to_input) |-> !positive_ground_switch && !negative_ground_switch
            && !$past(positive_ground_switch) && !$past(negative_ground_switch);
    endproperty
    a_gnd: assert property (p_gnd) else $error("switch order");
    property p_msb;
        $rose(busy) |-> ##2 dac_positive_ref == {1'b1, {(BITS-1){1'b0}}};
    endproperty
    a_msb: assert property (p_msb) else $error("msb trial");
    property p_cmp;
        dac_positive_ref != 0 |-> dac_negative_ref == ~dac_positive_ref;
    endproperty
    a_cmp: assert property (p_cmp) else $error("arrays");
    property p_done;
        $rose(busy) |-> !result_valid[*8] ##12 result_valid;
    endproperty
    a_done: assert property (p_done) else $error("done time");
    property p_end;
        result_valid |-> !busy && !powered_up && $past(busy);
    endproperty
    a_end: assert property (p_end) else $error("end state");
    property p_pwr;
        busy |-> powered_up;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power");
    property p_code;
        !result_valid |-> $stable(result_code);
    endproperty
    a_code: assert property (p_code) else $error("code hold");
    c_conv: cover property ($rose(busy));
    c_full: cover property (result_valid && result_code == '1);
    c_zero: cover property (result_valid && result_code == '0);
endmodule : scc_controller_props
bind scc_controller scc_controller_props #(.BITS(BITS)) props (.*);

// [test/scc_comparator_model.sv]
// Comparator model holding the sampled input level
`timescale 1ns/1ps
module scc_comparator_model (
    input wire logic [15:0] dac_positive_ref,
    input wire logic signed [31:0] level,
    output logic comparator_high
);
    assign comparator_high = $signed({16'h0, dac_positive_ref}) <= level;
endmodule : scc_comparator_model

// [test/scc_controller_tb.sv]
// Testbench for the conversion controller
`timescale 1ns/1ps
module scc_controller_tb;
    logic ref_clk = 0, sys_rst = 1, conversion_trigger = 0, comparator_high;
    logic positive_ground_switch, negative_ground_switch, array_to_input;
    logic result_valid, busy, powered_up;
    logic [15:0] dac_positive_ref, dac_negative_ref, result_code;
    logic signed [31:0] level = 0;
    int fails = 0, comparisons = 0;
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    logic [4:0] sw_state;
    assign sw_state = {busy, powered_up, positive_ground_switch, negative_ground_switch,
        array_to_input};
    scc_controller uut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .conversion_trigger(conversion_trigger),
        .comparator_high(comparator_high),
        .positive_ground_switch(positive_ground_switch),
        .negative_ground_switch(negative_ground_switch),
        .array_to_input(array_to_input),
        .dac_positive_ref(dac_positive_ref),
        .dac_negative_ref(dac_negative_ref),
        .result_code(result_code),
        .result_valid(result_valid),
        .busy(busy),
        .powered_up(powered_up)
    );
    scc_comparator_model cmp (
        .dac_positive_ref(dac_positive_ref),
        .level(level),
        .comparator_high(comparator_high)
    );
    task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task report_and_stop;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic run_conv(int lvl, logic [15:0] exp, bit tog);
        int n;
        level <= lvl;
        @(posedge ref_clk) conversion_trigger <= 1;
        n = 0;
        while (result_valid !== 1 && n < 40) begin
            @(posedge ref_clk) n++;
            if (tog && n < 13)
                conversion_trigger <= n[0];
            else if (n == 3)
                conversion_trigger <= 0;
            if (n == 5)
                chk("start", {11'h0, sw_state}, 16'h0019);
            if (n == 6)
                chk("ground", {11'h0, sw_state}, 16'h0018);
            if (n == 7) begin
                chk("trial", dac_positive_ref, 16'h8000);
                chk("mirror", dac_negative_ref, 16'h7fff);
            end
        end
        chk("valid", {15'h0, result_valid}, 16'h0001);
        chk("code", result_code, exp);
        chk("end", {11'h0, sw_state}, 16'h0007);
        chk("rate", 16'(n <= scc_pkg::CYCLES_PER_SAMPLE), 16'h0001);
        repeat (3) @(posedge ref_clk);
    endtask : run_conv
    task automatic t_codes;
        int lv[5] = '{0, 1, 32767, 32768, 65535};
        foreach (lv[i])
            run_conv(lv[i], 16'(lv[i]), 0);
    endtask : t_codes
    task automatic t_range;
        run_conv(70000, 16'hffff, 0);
        run_conv(-5, 16'h0000, 0);
    endtask : t_range
    task automatic t_retrig;
        run_conv(21845, 16'h5555, 1);
        repeat (25) @(posedge ref_clk);
        chk("idle", {15'h0, busy}, 16'h0000);
        chk("hold", result_code, 16'h5555);
    endtask : t_retrig
    task automatic t_reset;
        level <= 1000;
        @(posedge ref_clk) conversion_trigger <= 1;
        repeat (3) @(posedge ref_clk);
        conversion_trigger <= 0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 0;
        @(posedge ref_clk);
        chk("rst sw", {11'h0, sw_state}, 16'h0007);
        chk("rst dac", dac_positive_ref | dac_negative_ref, 16'h0000);
        chk("rst code", result_code, 16'h0000);
        run_conv(12345, 16'h3039, 0);
    endtask : t_reset
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 0;
        @(posedge ref_clk);
        chk("acq", {11'h0, sw_state}, 16'h0007);
        t_codes;
        t_range;
        t_retrig;
        t_reset;
        report_and_stop;
    end
    initial begin
        #100000;
        fails++;
        report_and_stop;
    end
endmodule : scc_controller_tb
